// file: bench/universal_serial_shift_unit_bench.sv
`timescale 1ns/1ps
module universal_serial_shift_unit_bench;
    import ussu_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] mask;
        logic [7:0] exp;
        logic       err;
    } ussu_row_t;
    logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, timer0_ovf, gie;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        rerr, start_irq, ovf_irq, do_pin, do_oe, sda_out, sda_oe, scl_out, scl_oe, sda_low, scl_low;
    wire logic   sda_line, scl_line;
    int unsigned fail_count, total_checks;
    ussu_row_t   rows [5];

    // Open-drain lines with pull-ups
    assign sda_line = ~sda_low & (sda_oe ? sda_out : 1'b1);
    assign scl_line = ~scl_low & (scl_oe ? scl_out : 1'b1);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ussu_top i_dut (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .timer0_ovf_in(timer0_ovf), .gie_in(gie),
        .start_irq_out(start_irq), .ovf_irq_out(ovf_irq), .data_out_pin_out(do_pin),
        .data_out_pin_oe_out(do_oe), .serial_in_pin_in(sda_line), .serial_in_pin_out(sda_out),
        .serial_in_pin_oe_out(sda_oe), .serial_clock_pin_in(scl_line),
        .serial_clock_pin_out(scl_out), .serial_clock_pin_oe_out(scl_oe)
    );

    ussu_bus_peer i_peer (.sda_in(sda_line), .scl_in(scl_line), .sda_low_out(sda_low), .scl_low_out(scl_low));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic tick(input int unsigned k);
        repeat (k) @(posedge sys_clk);
    endtask : tick

    // One APB transfer; answer taken at the rising edge that shows pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, rdat, rerr);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, a, 8'h00, rdat, rerr);
        chk(rdat & {24'h0, m}, {24'h0, e});
    endtask : rdchk

    initial begin
        #300_000;
        fail_count++;
        close_out();
    end

    initial begin
        fail_count = 0;
        total_checks = 0;
        {arst_n, psel, penable, pwrite, timer0_ovf, gie} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rows = '{'{OFF_DATA, 8'ha5, 8'hff, 8'ha5, 1'b0}, '{OFF_STATUS, 8'h0b, 8'h0f, 8'h0b, 1'b0},
                 '{OFF_CTRL, 8'hcc, 8'hff, 8'hcc, 1'b0}, '{OFF_CTRL, 8'h0b, 8'hff, 8'h08, 1'b0},
                 '{8'h10, 8'h5a, 8'hff, 8'h00, 1'b1}};
        tick(2);
        arst_n <= 1'b1;
        rdchk(OFF_DATA, 8'hff, RST_DATA);
        rdchk(OFF_STATUS, 8'hef, {4'h0, RST_CNT});
        rdchk(OFF_CTRL, 8'hff, 8'h00);
        chk({do_oe, sda_oe, scl_oe}, 3'h0);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rdchk(rows[i].addr, rows[i].mask, rows[i].exp);
            chk(rerr, rows[i].err);
        end
        // Software strobe, three-wire, counter wrap
        gie <= 1'b1;
        wr(OFF_CTRL, 8'h00);
        wr(OFF_PORT, 8'h10);
        wr(OFF_CTRL, 8'h50);
        wr(OFF_DATA, 8'h80);
        tick(2);
        chk({do_oe, do_pin}, 2'b11);
        wr(OFF_STATUS, 8'h4f);
        wr(OFF_CTRL, 8'h52);
        rdchk(OFF_DATA, 8'hff, 8'h01);
        chk(do_pin, 1'b0);
        rdchk(OFF_STATUS, 8'h4f, 8'h40);
        chk(ovf_irq, 1'b1);
        wr(OFF_STATUS, 8'h40);
        tick(2);
        chk(ovf_irq, 1'b0);
        rdchk(OFF_STATUS, 8'h4f, 8'h00);
        // Timer overflow clock
        wr(OFF_CTRL, 8'h14);
        timer0_ovf <= 1'b1;
        tick(1);
        timer0_ovf <= 1'b0;
        rdchk(OFF_STATUS, 8'h0f, 8'h01);
        rdchk(OFF_DATA, 8'hff, 8'h03);
        // External clock in mode off, both edges counted
        wr(OFF_STATUS, 8'he0);
        wr(OFF_CTRL, 8'h08);
        i_peer.drive(1'b1, 1'b0);
        i_peer.clock_pulse();
        i_peer.drive(1'b1, 1'b1);
        rdchk(OFF_STATUS, 8'h8f, 8'h82);
        rdchk(OFF_DATA, 8'hff, 8'h06);
        wr(OFF_CTRL, 8'h0c);
        i_peer.clock_pulse();
        rdchk(OFF_DATA, 8'hff, 8'h0d);
        wr(OFF_STATUS, 8'h80);
        wr(OFF_CTRL, 8'h0a);
        wr(OFF_CTRL, 8'h0b);
        rdchk(OFF_STATUS, 8'h0f, 8'h01);
        rdchk(OFF_PORT, 8'h04, 8'h04);
        // Two-wire start, hold, stop; MSB loaded while latch closed, passed once it opens
        wr(OFF_CTRL, 8'h00);
        wr(OFF_DATA, 8'hff);
        wr(OFF_STATUS, 8'he0);
        wr(OFF_PORT, 8'h66);
        wr(OFF_CTRL, 8'ha8);
        tick(4);
        chk(sda_oe, 1'b0);
        i_peer.start_cond();
        tick(4);
        chk(start_irq, 1'b1);
        chk({scl_oe, scl_out}, 2'b10);
        rdchk(OFF_STATUS, 8'h90, 8'h90);
        gie <= 1'b0;
        tick(3);
        chk(start_irq, 1'b0);
        gie <= 1'b1;
        tick(3);
        chk(start_irq, 1'b1);
        wr(OFF_STATUS, 8'h80);
        tick(3);
        chk(scl_oe, 1'b0);
        i_peer.stop_cond();
        rdchk(OFF_STATUS, 8'h20, 8'h20);
        chk(start_irq, 1'b0);
        wr(OFF_STATUS, 8'h20);
        rdchk(OFF_STATUS, 8'h20, 8'h00);
        wr(OFF_DATA, 8'h7f);
        tick(3);
        chk(sda_oe, 1'b0);
        wr(OFF_CTRL, 8'ha0);
        tick(3);
        chk({sda_oe, sda_out}, 2'b10);
        // Mode 11 overflow hold
        wr(OFF_DATA, 8'hff);
        wr(OFF_CTRL, 8'h30);
        wr(OFF_STATUS, 8'hef);
        wr(OFF_CTRL, 8'h32);
        tick(3);
        chk({scl_oe, scl_out}, 2'b10);
        rdchk(OFF_STATUS, 8'h4f, 8'h40);
        wr(OFF_STATUS, 8'h40);
        tick(3);
        chk(scl_oe, 1'b0);
        chk(i_peer.stretch_miss, 32'h0);
        close_out();
    end
endmodule : universal_serial_shift_unit_bench

// file: bench/ussu_bus_peer.sv
`timescale 1ns/1ps
module ussu_bus_peer (
    // Resolved bus levels
    input  wire logic sda_in,
    input  wire logic scl_in,
    // Open-drain pulls, high pulls the line low
    output logic      sda_low_out,
    output logic      scl_low_out
);
    localparam real HALF_NS = 62.5;
    int unsigned stretch_miss;

    initial begin
        sda_low_out = 1'b0;
        scl_low_out = 1'b0;
        stretch_miss = 0;
    end

    // Set one line, then hold half a link period; link clock idles between frames
    task automatic drive(input logic on_sda, input logic level);
        if (on_sda) begin
            sda_low_out = ~level;
        end else begin
            scl_low_out = ~level;
        end
        #(HALF_NS);
    endtask : drive

    // A slave may stretch the clock, so see it really rise
    task automatic release_scl();
        int unsigned waited;
        waited = 0;
        scl_low_out = 1'b0;
        while (scl_in !== 1'b1 && waited < 100) begin
            #(HALF_NS);
            waited++;
        end
        if (scl_in !== 1'b1) begin
            stretch_miss++;
        end
        #(HALF_NS);
    endtask : release_scl

    task automatic start_cond();
        drive(1'b1, 1'b0);
        #(HALF_NS);
        drive(1'b0, 1'b0);
    endtask : start_cond

    task automatic stop_cond();
        drive(1'b1, 1'b0);
        release_scl();
        drive(1'b1, 1'b1);
    endtask : stop_cond

    task automatic clock_pulse();
        drive(1'b0, 1'b0);
        release_scl();
    endtask : clock_pulse
endmodule : ussu_bus_peer

// file: hw/ussu_cond_det.sv
`timescale 1ns/1ps
module ussu_cond_det (
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic arst_n_in,
    // Filtered bus levels
    input  wire logic sda_in,
    input  wire logic scl_in,
    // Detected conditions, one-cycle pulses
    output logic      start_out,
    output logic      stop_out
);
    logic sda_d_r;
    logic scl_d_r;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sda_d_r <= 1'b1;
            scl_d_r <= 1'b1;
        end else begin
            sda_d_r <= sda_in;
            scl_d_r <= scl_in;
        end
    end

    // Data compared against a delayed clock so clock is sampled stable
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_out <= 1'b0;
            stop_out  <= 1'b0;
        end else begin
            start_out <= sda_d_r & ~sda_in & scl_d_r & scl_in;
            stop_out  <= ~sda_d_r & sda_in & scl_d_r & scl_in;
        end
    end
endmodule : ussu_cond_det

// file: hw/ussu_sync.sv
`timescale 1ns/1ps
module ussu_sync (
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic arst_n_in,
    // Raw pin and filtered level
    input  wire logic pin_in,
    output logic      level_out
);
    logic q1_r;
    logic q2_r;
    logic q3_r;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q1_r <= 1'b1;
            q2_r <= 1'b1;
            q3_r <= 1'b1;
        end else begin
            q1_r <= pin_in;
            q2_r <= q1_r;
            q3_r <= q2_r;
        end
    end

    // Level follows only once stages two and three agree
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            level_out <= 1'b1;
        end else if (q2_r == q3_r) begin
            level_out <= q3_r;
        end
    end
endmodule : ussu_sync

// file: hw/ussu_top.sv
// How it works
// - Data register is shifter; write beats shift
// - Shift left per selected clock event
// - Active output pin fed from bit 7
// - Latch half-cycle external, always open internal
// - Open latch passes new MSB immediately
// - Start flag on start or clock edge
// - Start interrupt when flag and enables set
// - Start flag write-one clear releases hold
// - Counter wrap sets overflow flag, interrupt
// - Overflow flag write-one clear releases hold
// - Stop flag set on stop, no interrupt
// - Collision bit is MSB versus data pin
// - Counter readable and writable in status
// - Counter counts each selected clock; external clock both edges
// - External with strobe bit: toggle clocks counter
// - Inputs work the same in all modes
// - Mode off: pins are plain port pins
// - Three-wire: data-out overrides port value
// - Two-wire data pin open-drain from MSB/port
// - Two-wire clock low from port or start
// - Mode 11 also holds clock on overflow
// - Clock source encoding soft, timer, edges
// - Toggle strobe inverts clock port, reads zero
// - Soft strobe shifts and counts, reads zero
`timescale 1ns/1ps
module ussu_top
    import ussu_pkg::*;
(
    // Clock and reset
    input  wire logic                          sys_clk_in,
    input  wire logic                          arst_n_in,
    // APB slave
    input  wire logic                          psel_in,
    input  wire logic                          penable_in,
    input  wire logic                          pwrite_in,
    input  wire logic [ussu_pkg::ADDR_W-1:0]   paddr_in,
    input  wire logic [ussu_pkg::DATA_W-1:0]   pwdata_in,
    output logic      [ussu_pkg::DATA_W-1:0]   prdata_out,
    output logic                               pready_out,
    output logic                               pslverr_out,
    // System events
    input  wire logic                          timer0_ovf_in,
    input  wire logic                          gie_in,
    output logic                               start_irq_out,
    output logic                               ovf_irq_out,
    // Data-out pin
    output logic                               data_out_pin_out,
    output logic                               data_out_pin_oe_out,
    // Serial data pin
    input  wire logic                          serial_in_pin_in,
    output logic                               serial_in_pin_out,
    output logic                               serial_in_pin_oe_out,
    // Serial clock pin
    input  wire logic                          serial_clock_pin_in,
    output logic                               serial_clock_pin_out,
    output logic                               serial_clock_pin_oe_out
);
    import ussu_pkg::*;

    logic [7:0] sr_r;
    logic [7:0] sr_nxt;
    logic [3:0] cnt_r;
    logic       latch_r;
    logic       start_flag_r;
    logic       start_flag_nxt;
    logic       ovf_flag_r;
    logic       ovf_flag_nxt;
    logic       stop_flag_r;
    logic       start_hold_r;
    logic       ovf_hold_r;
    logic       sie_r;
    logic       oie_r;
    ussu_wm_t   wm_r;
    ussu_cs_t   cs_r;
    logic       clk_sel_r;
    logic [2:0] port_r;
    logic [2:0] ddr_r;
    logic       scl_d_r;
    logic       sda_f;
    logic       scl_f;
    logic       start_pulse;
    logic       stop_pulse;

    // Bus decode
    logic       setup_rd;
    logic       wr_acc;
    logic       wr_data;
    logic       wr_stat;
    logic       wr_ctrl;
    logic       wr_port;
    logic       mapped;

    // Clocking
    logic       scl_rise;
    logic       scl_fall;
    logic       sw_strobe;
    logic       tog_wr;
    logic       shift_ev;
    logic       cnt_ev;
    logic       cnt_wrap;
    logic       transparent;
    logic       two_wire;
    logic       start_ev;
    logic       collision;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        addr_hit = (a == off);
    endfunction : addr_hit

    ussu_sync u_sync_sda (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .pin_in     (serial_in_pin_in),
        .level_out  (sda_f)
    );

    ussu_sync u_sync_scl (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .pin_in     (serial_clock_pin_in),
        .level_out  (scl_f)
    );

    ussu_cond_det u_cond_det (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .sda_in     (sda_f),
        .scl_in     (scl_f),
        .start_out  (start_pulse),
        .stop_out   (stop_pulse)
    );

    assign mapped   = addr_hit(paddr_in, OFF_DATA) | addr_hit(paddr_in, OFF_STATUS)
                    | addr_hit(paddr_in, OFF_CTRL) | addr_hit(paddr_in, OFF_PORT);
    assign setup_rd = psel_in & ~penable_in;
    assign wr_acc   = psel_in & penable_in & pready_out & pwrite_in;
    assign wr_data  = wr_acc & addr_hit(paddr_in, OFF_DATA);
    assign wr_stat  = wr_acc & addr_hit(paddr_in, OFF_STATUS);
    assign wr_ctrl  = wr_acc & addr_hit(paddr_in, OFF_CTRL);
    assign wr_port  = wr_acc & addr_hit(paddr_in, OFF_PORT);

    // Serial clock edges, identical in every wire mode
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            scl_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_f;
        end
    end

    assign scl_rise  = scl_f & ~scl_d_r;
    assign scl_fall  = ~scl_f & scl_d_r;
    assign two_wire  = wm_r[1];
    assign sw_strobe = wr_ctrl & pwdata_in[CT_CLK] & (cs_r == CS_SOFT);
    assign tog_wr    = wr_ctrl & pwdata_in[CT_TOG];

    always_comb begin
        unique case (cs_r)
            CS_SOFT:  shift_ev = sw_strobe;
            CS_TIMER: shift_ev = timer0_ovf_in;
            CS_EXT_P: shift_ev = scl_rise;
            CS_EXT_N: shift_ev = scl_fall;
        endcase
    end

    assign cnt_ev   = cs_r[1] ? (clk_sel_r ? tog_wr : (scl_rise | scl_fall)) : shift_ev;
    assign cnt_wrap = cnt_ev & (cnt_r == CNT_MAX) & ~wr_stat;

    assign sr_nxt = wr_data ? pwdata_in[7:0] : (shift_ev ? {sr_r[6:0], sda_f} : sr_r);

    assign transparent = ~cs_r[1] | (cs_r[0] ? scl_f : ~scl_f);

    assign collision = sr_r[7] ^ sda_f;

    assign start_ev = (two_wire & start_pulse)
                    | (~two_wire & cs_r[1] & ~clk_sel_r & (scl_rise | scl_fall));

    // Set beats clear on start and stop flags; a status write blocks the counter wrap that sets overflow
    assign start_flag_nxt = start_ev | (start_flag_r & ~(wr_stat & pwdata_in[ST_START]));
    assign ovf_flag_nxt   = cnt_wrap | (ovf_flag_r & ~(wr_stat & pwdata_in[ST_OVF]));

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sr_r <= RST_DATA;
        end else begin
            sr_r <= sr_nxt;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            latch_r <= 1'b0;
        end else if (transparent) begin
            latch_r <= sr_nxt[7];
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_r <= RST_CNT;
        end else if (wr_stat) begin
            cnt_r <= pwdata_in[ST_CNT_HI:0];
        end else if (cnt_ev) begin
            cnt_r <= 4'(cnt_r + 4'h1);
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_flag_r <= 1'b0;
            ovf_flag_r   <= 1'b0;
            stop_flag_r  <= 1'b0;
        end else begin
            start_flag_r <= start_flag_nxt;
            ovf_flag_r   <= ovf_flag_nxt;
            stop_flag_r  <= (two_wire & stop_pulse)
                          | (stop_flag_r & ~(wr_stat & pwdata_in[ST_STOP]));
        end
    end

    // Clock holds, released when their flag is cleared
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_hold_r <= 1'b0;
            ovf_hold_r   <= 1'b0;
        end else begin
            start_hold_r <= start_flag_nxt & two_wire & (start_hold_r | scl_fall);
            ovf_hold_r   <= ovf_flag_nxt & (wm_r == WM_TWO_H) & (ovf_hold_r | cnt_wrap);
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sie_r     <= 1'b0;
            oie_r     <= 1'b0;
            wm_r      <= WM_OFF;
            cs_r      <= CS_SOFT;
            clk_sel_r <= 1'b0;
        end else if (wr_ctrl) begin
            sie_r     <= pwdata_in[CT_SIE];
            oie_r     <= pwdata_in[CT_OIE];
            wm_r      <= ussu_wm_t'(pwdata_in[CT_WM_HI:CT_WM_LO]);
            cs_r      <= ussu_cs_t'(pwdata_in[CT_CS_HI:CT_CS_LO]);
            clk_sel_r <= pwdata_in[CT_CLK];
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            port_r <= RST_PIN;
            ddr_r  <= RST_PIN;
        end else if (wr_port) begin
            port_r <= pwdata_in[PT_VAL_HI:PT_VAL_LO];
            ddr_r  <= pwdata_in[PT_DIR_HI:PT_DIR_LO];
        end else if (tog_wr) begin
            port_r[PIN_SCL] <= ~port_r[PIN_SCL];
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_irq_out <= 1'b0;
            ovf_irq_out   <= 1'b0;
        end else begin
            start_irq_out <= start_flag_r & sie_r & gie_in;
            ovf_irq_out   <= ovf_flag_r & oie_r & gie_in;
        end
    end

    // Pin drivers
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            data_out_pin_out        <= 1'b0;
            data_out_pin_oe_out     <= 1'b0;
            serial_in_pin_out       <= 1'b0;
            serial_in_pin_oe_out    <= 1'b0;
            serial_clock_pin_out    <= 1'b0;
            serial_clock_pin_oe_out <= 1'b0;
        end else begin
            data_out_pin_oe_out <= ddr_r[PIN_DO];
            data_out_pin_out    <= (wm_r == WM_THREE) ? latch_r : port_r[PIN_DO];
            if (two_wire) begin
                serial_in_pin_out       <= 1'b0;
                serial_in_pin_oe_out    <= ddr_r[PIN_SDA] & (~latch_r | ~port_r[PIN_SDA]);
                serial_clock_pin_out    <= 1'b0;
                serial_clock_pin_oe_out <= ddr_r[PIN_SCL]
                                         & (~port_r[PIN_SCL] | start_hold_r | ovf_hold_r);
            end else begin
                serial_in_pin_out       <= port_r[PIN_SDA];
                serial_in_pin_oe_out    <= ddr_r[PIN_SDA];
                serial_clock_pin_out    <= port_r[PIN_SCL];
                serial_clock_pin_oe_out <= ddr_r[PIN_SCL];
            end
        end
    end

    // APB: read data captured in setup, answer in the access cycle
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end else begin
            pready_out  <= setup_rd;
            pslverr_out <= setup_rd & ~mapped;
            if (setup_rd) begin
                prdata_out <= '0;
                if (addr_hit(paddr_in, OFF_DATA)) begin
                    prdata_out[7:0] <= sr_r;
                end else if (addr_hit(paddr_in, OFF_STATUS)) begin
                    prdata_out[7:0] <= {start_flag_r, ovf_flag_r, stop_flag_r, collision, cnt_r};
                end else if (addr_hit(paddr_in, OFF_CTRL)) begin
                    prdata_out[7:0] <= {sie_r, oie_r, wm_r, cs_r, 2'b00};
                end else if (addr_hit(paddr_in, OFF_PORT)) begin
                    prdata_out[7:0] <= {1'b0, ddr_r, 1'b0, port_r};
                end
            end
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_start_seen;
        two_wire && start_pulse;
    endsequence

    sequence s_hold_cause;
        two_wire && start_hold_r && ddr_r[PIN_SCL];
    endsequence

    a_write_beats_shift: assert property (wr_data |=> sr_r == $past(pwdata_in[7:0]))
        else $error("data write lost to a shift");

    a_shift_left_step: assert property (shift_ev && !wr_data |=> sr_r == {$past(sr_r[6:0]), $past(sda_f)})
        else $error("shift register did not shift left");

    a_start_flag_set: assert property (s_start_seen |=> start_flag_r)
        else $error("start condition did not set flag");

    a_start_irq_req: assert property (start_flag_r && sie_r && gie_in |=> start_irq_out)
        else $error("start interrupt not requested");

    a_ovf_wrap_flag: assert property (cnt_wrap |=> ovf_flag_r && cnt_r == 4'h0)
        else $error("counter wrap did not set overflow flag");

    a_ovf_flag_sticky: assert property (ovf_flag_r && !(wr_stat && pwdata_in[ST_OVF]) |=> ovf_flag_r)
        else $error("overflow flag cleared without write");

    a_cnt_increment: assert property (cnt_ev && !wr_stat |=> cnt_r == 4'($past(cnt_r) + 4'h1))
        else $error("counter did not increment");

    a_scl_start_hold: assert property (s_hold_cause |=> serial_clock_pin_oe_out && !serial_clock_pin_out)
        else $error("clock line not held after start");

    a_off_plain_pins: assert property (wm_r == WM_OFF |=> serial_clock_pin_oe_out == $past(ddr_r[PIN_SCL]))
        else $error("clock pin not plain port in off mode");

    a_ctrl_strobes_zero: assert property (pready_out && !pwrite_in && psel_in
                                          && addr_hit(paddr_in, OFF_CTRL) |-> prdata_out[1:0] == 2'b00)
        else $error("strobe bits did not read zero");

    a_collision_bit: assert property (two_wire && pready_out && !pwrite_in && psel_in
                                      && addr_hit(paddr_in, OFF_STATUS)
                                      |-> prdata_out[ST_COLL] == $past(collision))
        else $error("collision bit wrong");
endmodule : ussu_top

// file: shared/ussu_pkg.sv
package ussu_pkg;
    // Bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register byte addresses
    localparam logic [7:0] OFF_DATA   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CTRL   = 8'h08;
    localparam logic [7:0] OFF_PORT   = 8'h0c;

    // Status fields
    localparam int unsigned ST_START  = 7;
    localparam int unsigned ST_OVF    = 6;
    localparam int unsigned ST_STOP   = 5;
    localparam int unsigned ST_COLL   = 4;
    localparam int unsigned ST_CNT_HI = 3;

    // Control fields
    localparam int unsigned CT_SIE    = 7;
    localparam int unsigned CT_OIE    = 6;
    localparam int unsigned CT_WM_HI  = 5;
    localparam int unsigned CT_WM_LO  = 4;
    localparam int unsigned CT_CS_HI  = 3;
    localparam int unsigned CT_CS_LO  = 2;
    localparam int unsigned CT_CLK    = 1;
    localparam int unsigned CT_TOG    = 0;

    // Port register fields: output values low, directions high
    localparam int unsigned PT_VAL_LO = 0;
    localparam int unsigned PT_VAL_HI = 2;
    localparam int unsigned PT_DIR_LO = 4;
    localparam int unsigned PT_DIR_HI = 6;

    // Pin index inside the port/direction fields
    localparam int unsigned PIN_DO  = 0;
    localparam int unsigned PIN_SDA = 1;
    localparam int unsigned PIN_SCL = 2;

    // Reset values and counter maximum
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [3:0] RST_CNT  = 4'h0;
    localparam logic [2:0] RST_PIN  = 3'h0;
    localparam logic [3:0] CNT_MAX  = 4'hf;

    typedef enum logic [1:0] {
        WM_OFF   = 2'b00,
        WM_THREE = 2'b01,
        WM_TWO   = 2'b10,
        WM_TWO_H = 2'b11
    } ussu_wm_t;

    typedef enum logic [1:0] {
        CS_SOFT  = 2'b00,
        CS_TIMER = 2'b01,
        CS_EXT_P = 2'b10,
        CS_EXT_N = 2'b11
    } ussu_cs_t;
endpackage : ussu_pkg
